// ===== src/arm_pkg.sv
// package: register map, field layout and carrier types of the result monitor block
package arm_pkg;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] ARM_OFS_RESULT0   = 8'h00; // normal results 0..11 at 0x00..0x2c
	localparam logic [7:0] ARM_OFS_PRIORITY  = 8'h30; // priority_result
	localparam logic [7:0] ARM_OFS_MON1CTL   = 8'h34; // monitor1_control
	localparam logic [7:0] ARM_OFS_DMAEN     = 8'h38; // dma_request_enable
	localparam logic [7:0] ARM_OFS_CMP1      = 8'h3c; // monitor1_compare_value_reg
	localparam logic [7:0] ARM_OFS_IRQSTAT   = 8'h40; // sticky event status, write one to clear
	localparam logic [7:0] ARM_OFS_IRQMASK   = 8'h44; // event mask
	// ==========================================
	// sizes and field positions
	localparam int         ARM_NUM_NORMAL    = 12;
	localparam int         ARM_RES_W         = 10;
	localparam int         ARM_RES_LSB       = 6;
	localparam int         ARM_RES_MSB       = 15;
	localparam int         ARM_OVR_BIT       = 1;
	localparam int         ARM_STORED_BIT    = 0;
	localparam int         ARM_M1_EN_BIT     = 0;
	localparam int         ARM_M1_SEL_LSB    = 1;
	localparam int         ARM_M1_SEL_MSB    = 4;
	localparam int         ARM_M1_POL_BIT    = 5;
	localparam int         ARM_DMA_NORMAL    = 0;
	localparam int         ARM_DMA_PRIO      = 1;
	localparam int         ARM_DMA_MON0      = 2;
	localparam int         ARM_DMA_MON1      = 3;
	localparam int         ARM_NUM_EVT       = 4;
	localparam int         ARM_SEL_PRIO_BIT  = 3;
	localparam logic [31:0] ARM_RESET_WORD   = 32'h0000_0000;
	// ==========================================
	// carrier types
	typedef logic [ARM_RES_W-1:0] arm_res_t;
	typedef struct packed {
		arm_res_t value;   // stored conversion result
		logic     overrun; // overwritten before read
		logic     stored;  // holds an unread result
	} arm_slot_s;
	typedef struct packed {
		logic       valid;  // one-cycle store strobe
		logic [3:0] index;  // normal register index 0..11
		arm_res_t   value;  // result data
	} arm_store_s;
endpackage : arm_pkg

// ===== src/arm_result_slot.sv
// module: one result register with overrun and stored flags
`timescale 1ns/1ps
module arm_result_slot (
	// clock and reset
	input  wire logic            clk,
	input  wire logic            sys_rst,
	// store and read side
	input  wire logic            storeValid,
	input  wire arm_pkg::arm_res_t storeValue,
	input  wire logic            readHit,
	// held content
	output arm_pkg::arm_slot_s   slot
);
	import arm_pkg::*;

	arm_slot_s state;      // whole slot state
	arm_slot_s next_state; // next value

	// ==========================================
	// store and read-clear
	always_comb begin
		next_state = state;
		if (readHit) begin
			next_state.overrun = 1'b0; // cleared by read
			next_state.stored  = 1'b0; // cleared by read
		end
		// a store in the read cycle wins so no event is lost
		if (storeValid) begin
			next_state.value  = storeValue;
			next_state.stored = 1'b1;
			if (state.stored)
				next_state.overrun = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign slot = state;
endmodule : arm_result_slot

// ===== src/arm_monitor.sv
// module: second threshold monitor comparing one selected result
`timescale 1ns/1ps
module arm_monitor (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// control
	input  wire logic              enable,
	input  wire logic              polarity,
	input  wire logic [3:0]        sourceSelect,
	input  wire arm_pkg::arm_res_t compareValue,
	// store events
	input  wire arm_pkg::arm_store_s normalStore,
	input  wire logic              prioStore,
	input  wire arm_pkg::arm_res_t prioValue,
	// event out
	output logic                   hit
);
	import arm_pkg::*;

	typedef struct packed {
		logic hit; // one-cycle monitor event
	} arm_mon_s;
	arm_mon_s state;
	arm_mon_s next_state;

	// ==========================================
	// compare on each store into the selected register
	always_comb begin
		logic     selStore;
		arm_res_t selValue;
		selStore = 1'b0;
		selValue = '0;
		if (sourceSelect[ARM_SEL_PRIO_BIT]) begin // 1xxx picks priority
			selStore = prioStore;
			selValue = prioValue;
		end else begin
			selStore = normalStore.valid && (normalStore.index == sourceSelect);
			selValue = normalStore.value;
		end
		next_state.hit = 1'b0;
		if (enable && selStore) begin
			if (polarity)
				next_state.hit = selValue > compareValue;
			else
				next_state.hit = selValue < compareValue;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign hit = state.hit;
endmodule : arm_monitor

// ===== src/arm_regs.sv
// module: result registers, second monitor, dma request enables and apb slave
//
// Functional notes
// - monitor1_enable bit 0 turns monitor on
// - polarity 0 below, 1 above compare value
// - select 0-7 normal, 1xxx priority result
// - bit 3 routes monitor1 irq to dma
// - bit 2 routes monitor0 irq to dma
// - bit 1 routes priority done to dma
// - bit 0 routes normal done to dma
// - result in 15-6, other bits zero; code keeps overrun in bit 1, stored in bit 0
// - twelve identical normal result registers
// - overrun set when unread result overwritten
// - reading clears overrun flag
// - stored flag set on each store
// - reading result clears stored flag
// - priority register behaves like normal ones
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module arm_regs (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	// converter side store events
	input  wire arm_pkg::arm_store_s normalStore,
	input  wire logic                prioStore,
	input  wire arm_pkg::arm_res_t   prioValue,
	// completion events from converter and first monitor
	input  wire logic                normalDoneIrq,
	input  wire logic                priorityDoneIrq,
	input  wire logic                monitor0Irq,
	// outputs
	output logic                     monitor1Irq,
	output logic [3:0]               dmaRequest,
	output logic                     irq
);
	import arm_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		logic [5:0]            monitor1Control;  // polarity, select, enable
		logic [3:0]            dmaRequestEnable; // per-source dma enables
		arm_res_t              compareValue;     // monitor1_compare_value
		logic [ARM_NUM_EVT-1:0] irqStatus;       // sticky events
		logic [ARM_NUM_EVT-1:0] irqMask;         // 1 passes the event
		logic [31:0]           rdata;            // registered read data
		logic                  ready;            // access phase answer
		logic                  slverr;           // unmapped address
		logic [3:0]            dmaReq;           // one-cycle dma requests
		logic                  irqOut;           // level interrupt
	} arm_regs_s;
	arm_regs_s state;      // registered state
	arm_regs_s next_state; // next value

	arm_slot_s [ARM_NUM_NORMAL-1:0] normalSlot;   // normal result registers
	arm_slot_s                      prioSlot;     // priority result register
	logic [ARM_NUM_NORMAL-1:0]      normalRead;   // read-clear strobes
	logic                           prioRead;     // read-clear strobe
	logic                           mon1Hit;      // monitor event
	logic [ARM_NUM_EVT-1:0]         evt;          // all events, dma bit order
	logic                           readTake;     // completing read
	logic                           writeTake;    // completing write

	// format one result word, unused bits zero
	function automatic logic [31:0] slot_word(input arm_slot_s s);
		logic [31:0] w;
		w = ARM_RESET_WORD;
		w[ARM_RES_MSB:ARM_RES_LSB] = s.value;
		w[ARM_OVR_BIT]             = s.overrun;
		w[ARM_STORED_BIT]          = s.stored;
		return w;
	endfunction : slot_word

	// address hits a normal result register
	function automatic logic is_normal(input logic [7:0] a);
		return (a < ARM_OFS_PRIORITY) && (a[1:0] == 2'b00);
	endfunction : is_normal

	// access completes in the access phase when pready answers
	assign readTake  = psel && penable && state.ready && !pwrite;
	assign writeTake = psel && penable && state.ready && pwrite;

	// ==========================================
	// result registers
	genvar g;
	generate
		for (g = 0; g < ARM_NUM_NORMAL; g++) begin : gSlot
			assign normalRead[g] = readTake && is_normal(paddr) && (paddr[5:2] == 4'(g));
			arm_result_slot uSlot (
				.clk        (clk),
				.sys_rst    (sys_rst),
				.storeValid (normalStore.valid && (normalStore.index == 4'(g))),
				.storeValue (normalStore.value),
				.readHit    (normalRead[g]),
				.slot       (normalSlot[g])
			);
		end
	endgenerate

	assign prioRead = readTake && (paddr == ARM_OFS_PRIORITY);
	// priority slot shares the normal behaviour
	arm_result_slot uPrio (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.storeValid (prioStore),
		.storeValue (prioValue),
		.readHit    (prioRead),
		.slot       (prioSlot)
	);

	// ==========================================
	// second monitor
	arm_monitor uMon (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.enable       (state.monitor1Control[ARM_M1_EN_BIT]),
		.polarity     (state.monitor1Control[ARM_M1_POL_BIT]),
		.sourceSelect (state.monitor1Control[ARM_M1_SEL_MSB:ARM_M1_SEL_LSB]),
		.compareValue (state.compareValue),
		.normalStore  (normalStore),
		.prioStore    (prioStore),
		.prioValue    (prioValue),
		.hit          (mon1Hit)
	);

	// event vector in dma enable bit order
	always_comb begin
		evt                 = '0;
		evt[ARM_DMA_NORMAL] = normalDoneIrq;
		evt[ARM_DMA_PRIO]   = priorityDoneIrq;
		evt[ARM_DMA_MON0]   = monitor0Irq;
		evt[ARM_DMA_MON1]   = mon1Hit;
	end

	// ==========================================
	// register file, apb answer, dma and interrupt
	always_comb begin
		next_state = state;
		// one-wait answer: ready rises in the second access cycle
		next_state.ready  = psel && penable && !state.ready;
		next_state.slverr = 1'b0;
		next_state.rdata  = '0;
		if (psel && penable && !state.ready) begin
			if (is_normal(paddr) || paddr == ARM_OFS_PRIORITY) begin
				// results are read only; a write is ignored
				next_state.rdata = is_normal(paddr) ? slot_word(normalSlot[paddr[5:2]]) : slot_word(prioSlot);
			end else begin
				case (paddr)
					ARM_OFS_MON1CTL: next_state.rdata = {26'h0, state.monitor1Control};
					ARM_OFS_DMAEN:   next_state.rdata = {28'h0, state.dmaRequestEnable};
					ARM_OFS_CMP1:    next_state.rdata = {16'h0, state.compareValue, 6'h00};
					ARM_OFS_IRQSTAT: next_state.rdata = {28'h0, state.irqStatus};
					ARM_OFS_IRQMASK: next_state.rdata = {28'h0, state.irqMask};
					default:         next_state.slverr = 1'b1; // unmapped
				endcase
			end
		end
		if (writeTake) begin
			case (paddr)
				ARM_OFS_MON1CTL: next_state.monitor1Control  = pwdata[5:0];
				ARM_OFS_DMAEN:   next_state.dmaRequestEnable = pwdata[3:0];
				// software keeps the monitor off while writing here
				ARM_OFS_CMP1:    next_state.compareValue = pwdata[ARM_RES_MSB:ARM_RES_LSB];
				ARM_OFS_IRQSTAT: next_state.irqStatus = state.irqStatus & ~pwdata[ARM_NUM_EVT-1:0];
				ARM_OFS_IRQMASK: next_state.irqMask = pwdata[ARM_NUM_EVT-1:0];
				default: ;
			endcase
		end
		// set wins over a clear in the same cycle
		next_state.irqStatus = next_state.irqStatus | evt;
		// each enabled source raises one request per event
		next_state.dmaReq = evt & state.dmaRequestEnable;
		next_state.irqOut = |(next_state.irqStatus & next_state.irqMask);
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign prdata      = state.rdata;
	assign pready      = state.ready;
	assign pslverr     = state.slverr;
	assign monitor1Irq = mon1Hit;
	assign dmaRequest  = state.dmaReq;
	assign irq         = state.irqOut;
endmodule : arm_regs

// ===== test/arm_regs_checker.sv
// checker: bus and event assertions for the result monitor block
`timescale 1ns/1ps
module arm_regs_checker (
	// clock and reset
	input wire logic                clk,
	input wire logic                sys_rst,
	// apb slave
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// events
	input wire arm_pkg::arm_store_s normalStore,
	input wire logic                prioStore,
	input wire logic                normalDoneIrq,
	input wire logic                priorityDoneIrq,
	input wire logic                monitor0Irq,
	input wire logic                monitor1Irq,
	input wire logic [3:0]          dmaRequest
);
	// ==========
	// one clock domain, so one default for all
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	ready_wait_a: assert property (psel && $rose(penable) |=> pready) else $error("ready late");
	bad_addr_a: assert property (psel && $rose(penable) && paddr > 8'h44 |=> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	good_addr_a: assert property (psel && $rose(penable) && paddr <= 8'h44 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped refused");
	zero_bits_a: assert property (pready && psel && !pwrite && paddr <= 8'h30 |->
		prdata[31:16] == 16'h0 && prdata[5:2] == 4'h0) else $error("unused result bits set");
	dma_norm_a: assert property (dmaRequest[0] |-> $past(normalDoneIrq)) else $error("stray dma 0");
	dma_prio_a: assert property (dmaRequest[1] |-> $past(priorityDoneIrq)) else $error("stray dma 1");
	dma_mon0_a: assert property (dmaRequest[2] |-> $past(monitor0Irq)) else $error("stray dma 2");
	dma_mon1_a: assert property (dmaRequest[3] |-> $past(monitor1Irq)) else $error("stray dma 3");
	mon_cause_a: assert property (monitor1Irq |-> $past(normalStore.valid || prioStore))
		else $error("monitor hit without store");
	// main scenarios reached
	cover property (monitor1Irq);
	cover property (dmaRequest[3]);
	cover property (pslverr);
endmodule : arm_regs_checker

bind arm_regs arm_regs_checker u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.normalStore(normalStore), .prioStore(prioStore), .normalDoneIrq(normalDoneIrq),
	.priorityDoneIrq(priorityDoneIrq), .monitor0Irq(monitor0Irq), .monitor1Irq(monitor1Irq),
	.dmaRequest(dmaRequest));

// ===== test/arm_dma_model.sv
// model: dma controller counting request pulses per source
`timescale 1ns/1ps
module arm_dma_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// request pulses and counts
	input  wire logic [3:0] dmaRequest,
	output logic [3:0][7:0] reqCount
);
	// one transfer per pulse; this model only counts the pulses of each source
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reqCount <= '0;
		end else begin
			for (int b = 0; b < 4; b++) begin
				reqCount[b] <= reqCount[b] + 8'(dmaRequest[b]);
			end
		end
	end
endmodule : arm_dma_model

// ===== test/arm_regs_tb.sv
// testbench: result registers, second monitor, dma enables and interrupt
`timescale 1ns/1ps
module arm_regs_tb;
	import arm_pkg::*;
	// ==========
	// design inputs, all given at time zero
	logic            clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]      paddr = 8'h00;
	logic [31:0]     pwdata = 32'h0, prdata;
	logic            pready, pslverr, monitor1Irq, irq, prioStore = 0;
	logic            normalDoneIrq = 0, priorityDoneIrq = 0, monitor0Irq = 0;
	logic [3:0]      dmaRequest;
	arm_store_s      normalStore = '0;
	arm_res_t        prioValue = '0, v;
	logic [3:0][7:0] reqCount, expCnt;
	logic [4:0]      m;
	logic [32:0]     expQ[$]; // {pslverr, prdata} noted per read
	int              n_errors = 0, compares = 0;
	int              slots[3] = '{3, 11, 12};
	always #20 clk = ~clk;
	arm_regs u_arm_regs (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.normalStore(normalStore), .prioStore(prioStore), .prioValue(prioValue),
		.normalDoneIrq(normalDoneIrq), .priorityDoneIrq(priorityDoneIrq), .monitor0Irq(monitor0Irq),
		.monitor1Irq(monitor1Irq), .dmaRequest(dmaRequest), .irq(irq));
	arm_dma_model u_arm_dma_model (.clk(clk), .sys_rst(sys_rst), .dmaRequest(dmaRequest), .reqCount(reqCount));
	// ==========
	// shared tasks
	task automatic summarize;
		if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// request held until ready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		expQ.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// index 12 stands for the priority result
	task automatic store(input int i, input arm_res_t val);
		@(posedge clk);
		if (i == 12) {prioStore, prioValue} <= {1'b1, val};
		else normalStore <= '{1'b1, 4'(i), val};
		@(posedge clk);
		prioStore <= 1'b0;
		normalStore.valid <= 1'b0;
	endtask : store
	function automatic logic [32:0] res(input arm_res_t r, input logic [1:0] f);
		return {17'h0, r, 4'h0, f};
	endfunction : res
	// read data compared against the oldest note
	always @(posedge clk) if (pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata}, expQ.pop_front());
	// watchdog far beyond the roughly one thousand cycles the run needs
	initial begin
		#2_000_000;
		n_errors++;
		summarize;
	end
	// ==========
	// main sequence
	initial begin
		void'($urandom(32'hc250e77f));
		expCnt = '0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a <= 'h44; a += 4) rd(8'(a), 33'h0);
		rd(8'h48, {1'b1, 32'h0});
		apb(1'b1, 8'h08, 32'hffff_ffff); // result registers ignore writes
		rd(8'h08, 33'h0);
		foreach (slots[k]) begin
			v = arm_res_t'($urandom);
			store(slots[k], v);
			rd(8'(4 * slots[k]), res(v, 2'h1));
			rd(8'(4 * slots[k]), res(v, 2'h0));
			store(slots[k], v);
			store(slots[k], ~v);
			rd(8'(4 * slots[k]), res(~v, 2'h3));
			rd(8'(4 * slots[k]), res(~v, 2'h0));
		end
		apb(1'b1, 8'h3c, 32'h8000); // compare value 0x200, written while disabled
		for (int s = 0; s < 32; s++) begin
			m = 5'(s);
			apb(1'b1, 8'h34, {26'h0, m, 1'b1});
			v = m[4] ? 10'h201 + 10'($urandom % 256) : 10'h1ff - 10'($urandom % 256);
			store(m[3] ? 5 : 8, v); // unselected register never hits
			store(m[3] ? 12 : int'(m[2:0]), 10'h200); // equal value never hits
			store(m[3] ? 12 : int'(m[2:0]), v);
			repeat (2) @(posedge clk);
			rd(8'h40, 33'h8);
			apb(1'b1, 8'h40, 32'hf);
		end
		apb(1'b1, 8'h34, 32'h30);
		store(12, 10'h3ff);
		repeat (2) @(posedge clk);
		rd(8'h40, 33'h0);
		apb(1'b1, 8'h34, 32'h31);
		for (int e = 0; e < 16; e++) begin
			apb(1'b1, 8'h38, 32'(e));
			@(posedge clk);
			{normalDoneIrq, priorityDoneIrq, monitor0Irq} <= 3'b111;
			@(posedge clk);
			{normalDoneIrq, priorityDoneIrq, monitor0Irq} <= 3'b000;
			store(12, 10'h3ff);
			repeat (3) @(posedge clk);
			for (int b = 0; b < 4; b++) expCnt[b] += 8'(e >> b & 1);
		end
		for (int b = 0; b < 4; b++) check({25'h0, reqCount[b]}, {25'h0, expCnt[b]});
		check({32'h0, irq}, 33'h0); // all events masked
		apb(1'b1, 8'h44, 32'h4);
		repeat (2) @(posedge clk);
		check({32'h0, irq}, 33'h1);
		apb(1'b1, 8'h40, 32'h4);
		repeat (2) @(posedge clk);
		check({32'h0, irq}, 33'h0);
		rd(8'h40, 33'hb);
		rd(8'h38, 33'hf);
		rd(8'h34, 33'h31);
		rd(8'h3c, 33'h8000);
		repeat (4) @(posedge clk);
		summarize;
	end
endmodule : arm_regs_tb
